// ### core/fpp_pins.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// Summary of operation
// R01: invert tx clock, frame start, overhead pins
// R02: direction one drives frame start each frame
// R03: direction zero takes frame start as input
// R04: strobe mode zero gives payload enable
// R05: strobe mode one gives gapped payload clock
// R06: constant clock select overrides strobe mode
// R07: invert each receive side output independently
// R08: receive data force high resets set
// R09: host clears force high after alignment
// R10: force high plus invert holds data low
// R11: receive strobe is enable or gapped clock
// R12: invert transmit line clock and rails
// R13: positive rail force high, low if inverted
// R14: negative rail force high, low if inverted
// R15: invert receive line inputs before use
// R16: low summary shows framers one to eight
// R17: high summary shows framers nine to twelve
// R18: host reads both summaries first
// R19: constant clock on strobe, still invertible
// R20: loopback taps ahead of line overrides
// R21: force before invert, exclusive-or at pin
module fpp_pins #(
    parameter int N_FRAMERS = 12,
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // per framer interrupt requests, same clock
    input wire logic [N_FRAMERS-1:0] FRAMER_IRQ,
    // transmit system pins
    input wire logic TX_INPUT_CLOCK,
    input wire logic TX_FRAME_START_I,
    output logic TX_FRAME_START_O,
    output logic TX_FRAME_START_OE,
    input wire logic TX_OVERHEAD_DATA,
    input wire logic TX_OVERHEAD_ENABLE,
    input wire logic TX_PAYLOAD_DATA,
    output logic TX_PAYLOAD_ENABLE,
    // transmit core side
    input wire logic CORE_TX_FRAME_LAST,
    input wire logic CORE_TX_PAYLOAD_SLOT,
    input wire logic CORE_TX_BIT_CLOCK,
    output logic CORE_TX_CLOCK,
    output logic CORE_TX_FRAME_START,
    output logic CORE_TX_OH_DATA,
    output logic CORE_TX_OH_ENABLE,
    output logic CORE_TX_DATA,
    // receive core side
    input wire logic CORE_RX_PAYLOAD_SLOT,
    input wire logic CORE_RX_BIT_CLOCK,
    input wire logic CORE_RX_DATA,
    input wire logic CORE_RX_FRAME_START,
    input wire logic CORE_RX_SIGNAL_LOSS,
    input wire logic CORE_RX_OUT_OF_FRAME,
    // receive system pins
    output logic RX_PAYLOAD_ENABLE,
    output logic RX_PAYLOAD_OUT,
    output logic RX_OUTPUT_CLOCK,
    output logic RX_FRAME_START,
    output logic RX_SIGNAL_LOSS,
    output logic RX_OUT_OF_FRAME,
    // transmit line core side
    input wire logic CORE_TX_LINE_CLOCK,
    input wire logic CORE_TX_POS,
    input wire logic CORE_TX_NEG,
    // transmit line pins
    output logic TX_LINE_CLOCK,
    output logic TX_POSITIVE_RAIL,
    output logic TX_NEGATIVE_RAIL,
    // diagnostic loopback taps
    output logic LOOP_CLOCK,
    output logic LOOP_POS,
    output logic LOOP_NEG,
    // receive line pins and core side
    input wire logic RX_LINE_CLOCK,
    input wire logic RX_POSITIVE_RAIL,
    input wire logic RX_NEGATIVE_RAIL,
    output logic CORE_RX_LINE_CLOCK,
    output logic CORE_RX_POS,
    output logic CORE_RX_NEG
);
    import fpp_pkg::*;

    // refuse sizes the summary registers cannot hold
    initial begin
        if (N_FRAMERS < 1 || N_FRAMERS > IRQ_MAX || ADDR_W < 8)
            $error("fpp_pins: unsupported parameter values");
    end

    // software visible control
    logic [7:0] tx_clock_ctrl; // only the constant clock bit is stored
    logic [7:0] tx_sys; // transmit system pin control
    logic [7:0] rx_pin; // receive pin control
    logic [7:0] line_pol; // line pin polarity control
    // summary views of the framer requests
    logic [IRQ_MAX-1:0] irq_all;
    logic [7:0] irq_low;
    logic [7:0] irq_high;
    // pin synchronisers: stage one feeds stage two only
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [7:0] pin_raw;
    logic [7:0] pin_inv;
    // bus decode
    logic [5:0] word_idx;
    logic setup_phase;
    logic access_phase;
    logic mapped;
    logic wr_en;
    logic [31:0] next_rdata;

    // word index; low address bits ignored since every register is a word
    assign word_idx = PADDR[7:2];
    assign setup_phase = PSEL && !PENABLE;
    assign access_phase = PSEL && PENABLE;

    // map test for the error answer; the read mux decodes the index by its own case
    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx >= IDX_TX_CLOCK_CTRL) && (idx <= IDX_IRQ_HIGH);
    endfunction

    assign mapped = is_mapped(word_idx);
    // writes land only at the completing edge, and only while enabled
    assign wr_en = access_phase && PWRITE && CE && PSTRB[0];

    // zero wait states; a frozen block stalls the bus instead
    always_comb begin
        PREADY = CE;
        PSLVERR = access_phase && !mapped;
    end

    // pad the request vector so both summaries have fixed width
    always_comb begin
        irq_all = '0;
        irq_all[N_FRAMERS-1:0] = FRAMER_IRQ;
    end
    assign irq_low = irq_all[IRQ_LOW_W-1:0]; // R16
    // upper nibble unused and reads zero
    assign irq_high = {4'h0, irq_all[IRQ_MAX-1:IRQ_LOW_W]}; // R17

    // read mux, sampled in the setup cycle so data comes from a flop
    always_comb begin
        next_rdata = 32'h0;
        case (word_idx)
            IDX_TX_CLOCK_CTRL: next_rdata[7:0] = tx_clock_ctrl;
            IDX_TX_SYS: next_rdata[7:0] = tx_sys;
            IDX_RX_PIN: next_rdata[7:0] = rx_pin;
            IDX_LINE_POL: next_rdata[7:0] = line_pol;
            IDX_IRQ_LOW: next_rdata[7:0] = irq_low; // R16
            IDX_IRQ_HIGH: next_rdata[7:0] = irq_high; // R17
            default: next_rdata = 32'h0; // unmapped reads zero
        endcase
    end

    // read data register
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PRDATA <= 32'h0;
        end else if (CE && setup_phase && !PWRITE) begin
            PRDATA <= next_rdata;
        end
    end

    // control registers; summaries are read only and ignore writes
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            tx_clock_ctrl <= RST_TX_CLOCK_CTRL;
            tx_sys <= RST_TX_SYS; // R03
            rx_pin <= RST_RX_PIN; // R08
            line_pol <= RST_LINE_POL;
        end else if (wr_en) begin
            case (word_idx)
                IDX_TX_CLOCK_CTRL: tx_clock_ctrl[B_TX_CONST_CLK] <= PWDATA[B_TX_CONST_CLK];
                IDX_TX_SYS: tx_sys <= PWDATA[7:0];
                IDX_RX_PIN: rx_pin <= PWDATA[7:0];
                IDX_LINE_POL: line_pol <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // pins from outside are asynchronous: two flops before any use
    assign pin_raw = {RX_NEGATIVE_RAIL, RX_POSITIVE_RAIL, RX_LINE_CLOCK, TX_PAYLOAD_DATA,
                      TX_OVERHEAD_ENABLE, TX_OVERHEAD_DATA, TX_FRAME_START_I, TX_INPUT_CLOCK};
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else if (CE) begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // per pin invert controls, in the same order as pin_raw
    assign pin_inv = {line_pol[B_RX_NEGATIVE_RAIL_INV], line_pol[B_RX_POSITIVE_RAIL_INV], line_pol[B_RCLK_INV],
                      tx_sys[B_TX_DATA_INV], tx_sys[B_TX_OHEN_INV], tx_sys[B_TX_OH_INV],
                      tx_sys[B_TX_SOF_INV], tx_sys[B_TX_CLK_INV]};

    // inputs handed to the core after polarity correction
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            CORE_TX_CLOCK <= 1'b0;
            CORE_TX_FRAME_START <= 1'b0;
            CORE_TX_OH_DATA <= 1'b0;
            CORE_TX_OH_ENABLE <= 1'b0;
            CORE_TX_DATA <= 1'b0;
            CORE_RX_LINE_CLOCK <= 1'b0;
            CORE_RX_POS <= 1'b0;
            CORE_RX_NEG <= 1'b0;
        end else if (CE) begin
            CORE_TX_CLOCK <= pin_sync[0] ^ pin_inv[0]; // R01
            // an output-mode pin echoes our own drive, so mask it out
            CORE_TX_FRAME_START <= (pin_sync[1] ^ pin_inv[1]) && !tx_sys[B_TX_SOF_DIR]; // R01 R03
            CORE_TX_OH_DATA <= pin_sync[2] ^ pin_inv[2]; // R01
            CORE_TX_OH_ENABLE <= pin_sync[3] ^ pin_inv[3]; // R01
            CORE_TX_DATA <= pin_sync[4] ^ pin_inv[4];
            CORE_RX_LINE_CLOCK <= pin_sync[5] ^ pin_inv[5]; // R15
            CORE_RX_POS <= pin_sync[6] ^ pin_inv[6]; // R15
            CORE_RX_NEG <= pin_sync[7] ^ pin_inv[7]; // R15
        end
    end

    // strobe select: constant clock wins, then gapped clock, then enable
    function automatic logic strobe_sel(input logic const_clk, input logic gapped,
                                        input logic slot, input logic bit_clk);
        if (const_clk)
            strobe_sel = bit_clk;
        else if (gapped)
            strobe_sel = bit_clk && slot;
        else
            strobe_sel = slot;
    endfunction

    // force applied first, then the pin inversion
    function automatic logic force_inv(input logic d, input logic frc, input logic inv);
        force_inv = (d || frc) ^ inv;
    endfunction

    // transmit frame start direction and strobe pin
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            TX_FRAME_START_O <= 1'b0;
            TX_FRAME_START_OE <= 1'b0;
            TX_PAYLOAD_ENABLE <= 1'b0;
        end else if (CE) begin
            // pulse in the last input clock cycle of the frame
            TX_FRAME_START_O <= CORE_TX_FRAME_LAST ^ tx_sys[B_TX_SOF_INV]; // R02
            TX_FRAME_START_OE <= tx_sys[B_TX_SOF_DIR]; // R02 R03
            TX_PAYLOAD_ENABLE <= strobe_sel(tx_clock_ctrl[B_TX_CONST_CLK], tx_sys[B_TX_STROBE_MODE],
                                            CORE_TX_PAYLOAD_SLOT, CORE_TX_BIT_CLOCK)
                                 ^ tx_sys[B_TX_STROBE_INV]; // R04 R05 R06 R19
        end
    end

    // receive system outputs
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            RX_PAYLOAD_ENABLE <= 1'b0;
            RX_PAYLOAD_OUT <= 1'b1; // force high is set out of reset
            RX_OUTPUT_CLOCK <= 1'b0;
            RX_FRAME_START <= 1'b0;
            RX_SIGNAL_LOSS <= 1'b0;
            RX_OUT_OF_FRAME <= 1'b0;
        end else if (CE) begin
            RX_PAYLOAD_ENABLE <= strobe_sel(1'b0, rx_pin[B_RX_STROBE_MODE], CORE_RX_PAYLOAD_SLOT,
                                            CORE_RX_BIT_CLOCK) ^ rx_pin[B_RX_STROBE_INV]; // R11 R07
            RX_PAYLOAD_OUT <= force_inv(CORE_RX_DATA, rx_pin[B_RX_FORCE_HIGH],
                                        rx_pin[B_RX_DATA_INV]); // R08 R10 R21
            RX_OUTPUT_CLOCK <= CORE_RX_BIT_CLOCK ^ rx_pin[B_RX_OCLK_INV]; // R07
            RX_FRAME_START <= CORE_RX_FRAME_START ^ rx_pin[B_RX_SOF_INV]; // R07
            RX_SIGNAL_LOSS <= CORE_RX_SIGNAL_LOSS ^ rx_pin[B_RX_LOS_INV]; // R07
            RX_OUT_OF_FRAME <= CORE_RX_OUT_OF_FRAME ^ rx_pin[B_RX_OOF_INV]; // R07
        end
    end

    // transmit line outputs and loopback taps
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            TX_LINE_CLOCK <= 1'b0;
            TX_POSITIVE_RAIL <= 1'b0;
            TX_NEGATIVE_RAIL <= 1'b0;
            LOOP_CLOCK <= 1'b0;
            LOOP_POS <= 1'b0;
            LOOP_NEG <= 1'b0;
        end else if (CE) begin
            TX_LINE_CLOCK <= CORE_TX_LINE_CLOCK ^ line_pol[B_TX_LINE_CLOCK_INV]; // R12
            TX_POSITIVE_RAIL <= force_inv(CORE_TX_POS, line_pol[B_TX_POSITIVE_RAIL_FORCE],
                                          line_pol[B_TX_POSITIVE_RAIL_INV]); // R12 R13 R21
            TX_NEGATIVE_RAIL <= force_inv(CORE_TX_NEG, line_pol[B_TX_NEGATIVE_RAIL_FORCE],
                                          line_pol[B_TX_NEGATIVE_RAIL_INV]); // R12 R14 R21
            // taps ignore the pin overrides, so local test traffic survives
            LOOP_CLOCK <= CORE_TX_LINE_CLOCK; // R20
            LOOP_POS <= CORE_TX_POS; // R20
            LOOP_NEG <= CORE_TX_NEG; // R20
        end
    end

    // named steps of a summary read
    sequence s_rd_low_setup;
        CE && setup_phase && !PWRITE && word_idx == IDX_IRQ_LOW;
    endsequence
    sequence s_rd_high_setup;
        CE && setup_phase && !PWRITE && word_idx == IDX_IRQ_HIGH;
    endsequence

    property p_rx_force_high;
        @(posedge CLK_SYS) disable iff (RST)
        (CE && rx_pin[B_RX_FORCE_HIGH] && !rx_pin[B_RX_DATA_INV]) |=> RX_PAYLOAD_OUT;
    endproperty
    a_rx_force_high: assert property (p_rx_force_high) else $error("rx data not forced high"); // R08

    property p_rx_force_low;
        @(posedge CLK_SYS) disable iff (RST)
        (CE && rx_pin[B_RX_FORCE_HIGH] && rx_pin[B_RX_DATA_INV]) |=> !RX_PAYLOAD_OUT;
    endproperty
    a_rx_force_low: assert property (p_rx_force_low) else $error("rx data not forced low"); // R10

    property p_rx_force_reset;
        @(posedge CLK_SYS) RST |=> (rx_pin[B_RX_FORCE_HIGH] && RX_PAYLOAD_OUT);
    endproperty
    a_rx_force_reset: assert property (p_rx_force_reset) else $error("force high not set by reset"); // R08

    property p_tx_positive_rail_force;
        @(posedge CLK_SYS) disable iff (RST)
        (CE && line_pol[B_TX_POSITIVE_RAIL_FORCE]) |=> (TX_POSITIVE_RAIL == $past(line_pol[B_TX_POSITIVE_RAIL_INV]) ^ 1'b1);
    endproperty
    a_tx_positive_rail_force: assert property (p_tx_positive_rail_force) else $error("positive rail force wrong"); // R13

    property p_tx_negative_rail_force;
        @(posedge CLK_SYS) disable iff (RST)
        (CE && line_pol[B_TX_NEGATIVE_RAIL_FORCE]) |=> (TX_NEGATIVE_RAIL == $past(line_pol[B_TX_NEGATIVE_RAIL_INV]) ^ 1'b1);
    endproperty
    a_tx_negative_rail_force: assert property (p_tx_negative_rail_force) else $error("negative rail force wrong"); // R14

    property p_sof_out;
        @(posedge CLK_SYS) disable iff (RST)
        (CE && tx_sys[B_TX_SOF_DIR]) |=>
            (TX_FRAME_START_OE && TX_FRAME_START_O == ($past(CORE_TX_FRAME_LAST) ^ $past(tx_sys[B_TX_SOF_INV])));
    endproperty
    a_sof_out: assert property (p_sof_out) else $error("frame start output wrong"); // R02

    property p_sof_in;
        @(posedge CLK_SYS) disable iff (RST)
        (CE && !tx_sys[B_TX_SOF_DIR]) |=> !TX_FRAME_START_OE;
    endproperty
    a_sof_in: assert property (p_sof_in) else $error("frame start driven in input mode"); // R03

    property p_tx_const_clk;
        @(posedge CLK_SYS) disable iff (RST)
        (CE && tx_clock_ctrl[B_TX_CONST_CLK]) |=>
            (TX_PAYLOAD_ENABLE == ($past(CORE_TX_BIT_CLOCK) ^ $past(tx_sys[B_TX_STROBE_INV])));
    endproperty
    a_tx_const_clk: assert property (p_tx_const_clk) else $error("constant clock not on strobe"); // R06

    property p_tx_enable_mode;
        @(posedge CLK_SYS) disable iff (RST)
        (CE && !tx_clock_ctrl[B_TX_CONST_CLK] && !tx_sys[B_TX_STROBE_MODE] && !tx_sys[B_TX_STROBE_INV])
            |=> (TX_PAYLOAD_ENABLE == $past(CORE_TX_PAYLOAD_SLOT));
    endproperty
    a_tx_enable_mode: assert property (p_tx_enable_mode) else $error("tx enable mode wrong"); // R04

    property p_tx_gapped_mode;
        @(posedge CLK_SYS) disable iff (RST)
        (CE && !tx_clock_ctrl[B_TX_CONST_CLK] && tx_sys[B_TX_STROBE_MODE] && !tx_sys[B_TX_STROBE_INV]
            && !CORE_TX_PAYLOAD_SLOT) |=> !TX_PAYLOAD_ENABLE;
    endproperty
    a_tx_gapped_mode: assert property (p_tx_gapped_mode) else $error("gapped clock in overhead"); // R05
    property p_rx_gapped_mode;
        @(posedge CLK_SYS) disable iff (RST)
        (CE && rx_pin[B_RX_STROBE_MODE] && !rx_pin[B_RX_STROBE_INV])
            |=> (RX_PAYLOAD_ENABLE == ($past(CORE_RX_BIT_CLOCK) && $past(CORE_RX_PAYLOAD_SLOT)));
    endproperty
    a_rx_gapped_mode: assert property (p_rx_gapped_mode) else $error("rx gapped clock wrong"); // R11
    property p_irq_low_read;
        @(posedge CLK_SYS) disable iff (RST)
        s_rd_low_setup |=> (PRDATA == {24'h0, $past(irq_low)});
    endproperty
    a_irq_low_read: assert property (p_irq_low_read) else $error("low summary read wrong"); // R16
    property p_irq_high_read;
        @(posedge CLK_SYS) disable iff (RST)
        s_rd_high_setup |=> (PRDATA[31:4] == 28'h0 && PRDATA[3:0] == $past(irq_all[IRQ_MAX-1:IRQ_LOW_W]));
    endproperty
    a_irq_high_read: assert property (p_irq_high_read) else $error("high summary read wrong"); // R17
endmodule // fpp_pins

// ### core/fpp_pkg.sv
package fpp_pkg;
    // register word indices; byte address is four times the index
    localparam logic [5:0] IDX_TX_CLOCK_CTRL = 6'h02;
    localparam logic [5:0] IDX_TX_SYS = 6'h03;
    localparam logic [5:0] IDX_RX_PIN = 6'h04;
    localparam logic [5:0] IDX_LINE_POL = 6'h05;
    localparam logic [5:0] IDX_IRQ_LOW = 6'h06;
    localparam logic [5:0] IDX_IRQ_HIGH = 6'h07;
    // reset values
    localparam logic [7:0] RST_TX_CLOCK_CTRL = 8'h00;
    localparam logic [7:0] RST_TX_SYS = 8'h00;
    localparam logic [7:0] RST_RX_PIN = 8'h10;
    localparam logic [7:0] RST_LINE_POL = 8'h00;
    // transmit clock control field
    localparam int B_TX_CONST_CLK = 6;
    // transmit system pin control fields
    localparam int B_TX_STROBE_INV = 0;
    localparam int B_TX_DATA_INV = 1;
    localparam int B_TX_CLK_INV = 2;
    localparam int B_TX_SOF_INV = 3;
    localparam int B_TX_OH_INV = 4;
    localparam int B_TX_OHEN_INV = 5;
    localparam int B_TX_SOF_DIR = 6;
    localparam int B_TX_STROBE_MODE = 7;
    // receive pin control fields
    localparam int B_RX_STROBE_INV = 0;
    localparam int B_RX_DATA_INV = 1;
    localparam int B_RX_OCLK_INV = 2;
    localparam int B_RX_SOF_INV = 3;
    localparam int B_RX_FORCE_HIGH = 4;
    localparam int B_RX_LOS_INV = 5;
    localparam int B_RX_OOF_INV = 6;
    localparam int B_RX_STROBE_MODE = 7;
    // line pin polarity fields
    localparam int B_TX_LINE_CLOCK_INV = 0;
    localparam int B_TX_POSITIVE_RAIL_INV = 1;
    localparam int B_TX_NEGATIVE_RAIL_INV = 2;
    localparam int B_TX_POSITIVE_RAIL_FORCE = 3;
    localparam int B_TX_NEGATIVE_RAIL_FORCE = 4;
    localparam int B_RCLK_INV = 5;
    localparam int B_RX_POSITIVE_RAIL_INV = 6;
    localparam int B_RX_NEGATIVE_RAIL_INV = 7;
    // framers in the low summary register, and in both summaries together
    localparam int IRQ_LOW_W = 8;
    localparam int IRQ_MAX = 12;
endpackage

// ### sim/fpp_far.sv
`timescale 1ns/1ps
// stand-in for the system framing logic and the line unit around the block
module fpp_far #(
    parameter int FRAME_LEN = 12, // bit times per frame, kept short for run time
    parameter int OH_LEN = 3 // overhead bit times at the head of each frame
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // tx system pins: input clock, frame start, overhead data, overhead enable, payload data
    output logic [4:0] tx_sys = 5'h00,
    // tx core: frame last, payload slot, bit clock
    output logic [2:0] tx_core = 3'h0,
    // rx core: payload slot, bit clock, data, frame start, signal loss, out of frame
    output logic [5:0] rx_core = 6'h00,
    // tx line core side: clock, positive rail, negative rail
    output logic [2:0] tx_line = 3'h0,
    // rx line pins: clock, positive rail, negative rail
    output logic [2:0] rx_line = 3'h0
);
    logic [7:0] cnt = 8'h00; // bit time within the frame
    logic bclk = 1'b0; // bit clock, one toggle per system cycle
    logic [31:0] rnd; // fresh noise each cycle so stale values never pass
    // frame counter wraps so that a frame end recurs
    always @(posedge clk_sys) begin
        cnt <= (rst || cnt == 8'(FRAME_LEN - 1)) ? 8'h00 : cnt + 8'h01;
        bclk <= rst ? 1'b0 : ~bclk;
    end
    // all far side levels change just after the edge
    always @(posedge clk_sys) begin
        rnd = $urandom;
        tx_sys <= {~bclk, cnt == 8'(FRAME_LEN - 1), rnd[2:0]};
        tx_core <= {cnt == 8'(FRAME_LEN - 1), cnt >= 8'(OH_LEN), bclk};
        rx_core <= {cnt >= 8'(OH_LEN), bclk, rnd[3], cnt == 8'h00, rnd[5:4]};
        tx_line <= {bclk, rnd[7:6]};
        rx_line <= {~bclk, rnd[9:8]};
    end
endmodule // fpp_far

// ### sim/tb.sv
`timescale 1ns/1ps
// self-checking bench for pin polarity, overrides and framer summaries
module tb;
    import fpp_pkg::*;
    logic CLK_SYS = 1'b0; // 250 MHz
    logic RST = 1'b1; // held four cycles
    logic CE = 1'b1; // clock enable
    logic PSEL = 1'b0; // apb select
    logic PENABLE = 1'b0; // apb access phase
    logic PWRITE = 1'b0; // apb direction
    logic [7:0] PADDR = 8'h00; // byte address
    logic [31:0] PWDATA = 32'h0; // write data
    logic [3:0] PSTRB = 4'hf; // byte strobes
    wire [31:0] PRDATA; // read data
    wire PREADY, PSLVERR, tpe, sfo, sfoe; // answers and single pins
    logic [11:0] irq = 12'h000; // per framer requests
    wire [4:0] s, tco; // tx system pins in, core copies out
    wire [2:0] ct, tl, rl, lto, lpo, cro; // line and core groups
    wire [5:0] cr, rxo; // rx core in, rx pins out
    logic [7:0] cc_r, sy_r, rx_r, lp_r; // shadow of programmed registers
    logic mon = 1'b0; // pin checks armed only while registers are settled
    logic [23:0] hp = 24'h0; // three cycles of async pin history
    logic [11:0] pcv = 12'h0; // one cycle of core input history
    int failures = 0;
    int comparisons = 0;
    // the frame start pin is two-way: the device wins while it drives
    wire sof_w = (sfoe === 1'b1) ? sfo : s[3];
    wire [7:0] p3 = hp[23:16];
    wire [2:0] pc = pcv[11:9];
    wire [5:0] pcr = pcv[8:3];
    wire [2:0] ptl = pcv[2:0];
    always #2 CLK_SYS = ~CLK_SYS;
    fpp_far far (.clk_sys(CLK_SYS), .rst(RST), .tx_sys(s), .tx_core(ct), .rx_core(cr), .tx_line(tl), .rx_line(rl));
    fpp_pins dut (
        .CLK_SYS, .RST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR,
        .FRAMER_IRQ(irq), .TX_INPUT_CLOCK(s[4]), .TX_FRAME_START_I(sof_w), .TX_FRAME_START_O(sfo),
        .TX_FRAME_START_OE(sfoe), .TX_OVERHEAD_DATA(s[2]), .TX_OVERHEAD_ENABLE(s[1]), .TX_PAYLOAD_DATA(s[0]),
        .TX_PAYLOAD_ENABLE(tpe), .CORE_TX_FRAME_LAST(ct[2]), .CORE_TX_PAYLOAD_SLOT(ct[1]), .CORE_TX_BIT_CLOCK(ct[0]),
        .CORE_TX_CLOCK(tco[4]), .CORE_TX_FRAME_START(tco[3]), .CORE_TX_OH_DATA(tco[2]), .CORE_TX_OH_ENABLE(tco[1]),
        .CORE_TX_DATA(tco[0]), .CORE_RX_PAYLOAD_SLOT(cr[5]), .CORE_RX_BIT_CLOCK(cr[4]), .CORE_RX_DATA(cr[3]),
        .CORE_RX_FRAME_START(cr[2]), .CORE_RX_SIGNAL_LOSS(cr[1]), .CORE_RX_OUT_OF_FRAME(cr[0]),
        .RX_PAYLOAD_ENABLE(rxo[5]), .RX_PAYLOAD_OUT(rxo[4]), .RX_OUTPUT_CLOCK(rxo[3]), .RX_FRAME_START(rxo[2]),
        .RX_SIGNAL_LOSS(rxo[1]), .RX_OUT_OF_FRAME(rxo[0]), .CORE_TX_LINE_CLOCK(tl[2]), .CORE_TX_POS(tl[1]),
        .CORE_TX_NEG(tl[0]), .TX_LINE_CLOCK(lto[2]), .TX_POSITIVE_RAIL(lto[1]), .TX_NEGATIVE_RAIL(lto[0]),
        .LOOP_CLOCK(lpo[2]), .LOOP_POS(lpo[1]), .LOOP_NEG(lpo[0]), .RX_LINE_CLOCK(rl[2]), .RX_POSITIVE_RAIL(rl[1]),
        .RX_NEGATIVE_RAIL(rl[0]), .CORE_RX_LINE_CLOCK(cro[2]), .CORE_RX_POS(cro[1]), .CORE_RX_NEG(cro[0])
    );
    // verdict and end of run
    task automatic summarize();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one comparison; four-state so an unknown never matches
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // shared strobe: constant clock wins, else gapped clock or payload enable
    function automatic logic strobe(input logic cc, input logic mode, input logic slot, input logic bclk);
        return cc ? bclk : (mode ? (bclk & slot) : slot);
    endfunction
    // apb transfer held until pready is seen high, bounded wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            $display("[ERR] pready expected 1 seen %b", PREADY);
            summarize();
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // one idle edge so the next call never reassigns the select in this time step
        @(posedge CLK_SYS);
    endtask
    // pin behaviour against the shadow registers; history taken every edge
    always @(posedge CLK_SYS) begin
        if (mon) begin
            chk("tx_core", {p3[7] ^ sy_r[2], ~sy_r[6] & (p3[6] ^ sy_r[3]), p3[5] ^ sy_r[4],
                p3[4] ^ sy_r[5], p3[3] ^ sy_r[1]}, tco);
            chk("tx_strobe", strobe(cc_r[6], sy_r[7], pc[1], pc[0]) ^ sy_r[0], tpe);
            chk("sof_out", {sy_r[6], pc[2] ^ sy_r[3]}, {sfoe, sfo});
            chk("rx_pins", {strobe(1'b0, rx_r[7], pcr[5], pcr[4]) ^ rx_r[0],
                (rx_r[4] | pcr[3]) ^ rx_r[1], pcr[4] ^ rx_r[2], pcr[2] ^ rx_r[3],
                pcr[1] ^ rx_r[5], pcr[0] ^ rx_r[6]}, rxo);
            chk("tx_line", {ptl[2] ^ lp_r[0], (lp_r[3] | ptl[1]) ^ lp_r[1],
                (lp_r[4] | ptl[0]) ^ lp_r[2]}, lto);
            chk("loop_tap", ptl, lpo);
            chk("rx_line", p3[2:0] ^ {lp_r[5], lp_r[6], lp_r[7]}, cro);
        end
        hp <= {hp[15:0], s[4], sof_w, s[2:0], rl};
        pcv <= {ct, cr, tl};
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge CLK_SYS);
        failures++;
        summarize();
    end
    // main sequence
    initial begin
        logic [31:0] rd;
        logic er;
        logic [31:0] v;
        logic [7:0] rv[4];
        logic [31:0] corner[5];
        rv = '{RST_TX_CLOCK_CTRL, RST_TX_SYS, RST_RX_PIN, RST_LINE_POL};
        corner = '{32'h00001000, 32'h00800218, 32'h4081121e, 32'h407fffff, 32'h004080e7};
        void'($urandom(32'h79ab));
        repeat (4) @(posedge CLK_SYS);
        RST <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        chk("rx_out_reset", 32'h1, rxo[4]);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, {IDX_TX_CLOCK_CTRL + 6'(i), 2'b00}, 32'h0, rd, er);
            chk("reset_value", {24'h0, rv[i]}, rd);
        end
        apb(1'b0, 8'h40, 32'h0, rd, er);
        chk("unmapped_err", 32'h1, er);
        chk("unmapped_data", 32'h0, rd);
        // a write with its low byte strobe off must leave the register alone
        PSTRB <= 4'h0;
        apb(1'b1, {IDX_RX_PIN, 2'b00}, 32'hef, rd, er);
        PSTRB <= 4'hf;
        apb(1'b0, {IDX_RX_PIN, 2'b00}, 32'h0, rd, er);
        chk("strobe_off", {24'h0, RST_RX_PIN}, rd);
        // table of awkward settings first, then random ones
        for (int k = 0; k < 30; k++) begin
            v = (k < 5) ? corner[k] : $urandom;
            mon <= 1'b0;
            @(posedge CLK_SYS);
            {cc_r, sy_r, rx_r, lp_r} = v;
            for (int i = 0; i < 4; i++) begin
                apb(1'b1, {IDX_TX_CLOCK_CTRL + 6'(i), 2'b00}, {24'h0, v[31 - 8 * i -: 8]}, rd, er);
            end
            for (int i = 0; i < 4; i++) begin
                apb(1'b0, {IDX_TX_CLOCK_CTRL + 6'(i), 2'b00}, 32'h0, rd, er);
                chk("readback", {24'h0, v[31 - 8 * i -: 8]} & (i == 0 ? 32'h40 : 32'hff),
                    rd & (i == 0 ? 32'h40 : 32'hffffffff));
                chk("mapped_err", 32'h0, er);
            end
            repeat (4) @(posedge CLK_SYS);
            mon <= 1'b1;
            repeat (24) @(posedge CLK_SYS);
        end
        // a write to the low summary first, which must be ignored, then both summaries read back
        for (int k = 0; k < 6; k++) begin
            irq <= (k == 0) ? 12'hfff : (k == 1) ? 12'h000 : 12'($urandom);
            apb(1'b1, {IDX_IRQ_LOW, 2'b00}, 32'hff, rd, er);
            apb(1'b0, {IDX_IRQ_LOW, 2'b00}, 32'h0, rd, er);
            chk("irq_low", {24'h0, irq[7:0]}, rd);
            apb(1'b0, {IDX_IRQ_HIGH, 2'b00}, 32'h0, rd, er);
            chk("irq_high", {28'h0, irq[11:8]}, rd);
        end
        mon <= 1'b0;
        CE <= 1'b0;
        @(posedge CLK_SYS);
        @(posedge CLK_SYS);
        chk("ready_ce_low", 32'h0, PREADY);
        CE <= 1'b1;
        summarize();
    end
endmodule // tb
